// ---- rtl/tpg_regs.svh ----
// Register offsets, field positions and reset values of the three-port GPIO block
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

// Printed offsets are not all multiples of four: indices, byte address = 4 * index
`define TPG_IDX_C_IN      5'h07
`define TPG_IDX_C_DIR     5'h08
`define TPG_IDX_C_OUT     5'h09
`define TPG_IDX_C_PUE     5'h0A
`define TPG_IDX_B_IN      5'h0B
`define TPG_IDX_B_DIR     5'h0C
`define TPG_IDX_B_OUT     5'h0D
`define TPG_IDX_B_PUE     5'h0E
`define TPG_IDX_A_IN      5'h0F
`define TPG_IDX_A_DIR     5'h10
`define TPG_IDX_A_OUT     5'h11
`define TPG_IDX_A_PUE     5'h12
`define TPG_IDX_CTRL      5'h13

`define TPG_WIDTH_A       4'h8
`define TPG_WIDTH_B       4'h4
`define TPG_WIDTH_C       4'h6

`define TPG_MASK_A        8'hFF
`define TPG_MASK_B        8'h0F
`define TPG_MASK_C        8'h3F
`define TPG_MASK_CTRL     8'h07

`define TPG_BIT_BBM_A     0
`define TPG_BIT_BBM_B     1
`define TPG_BIT_BBM_C     2

`define TPG_RST_REG       8'h00

`define TPG_RESP_OKAY     2'h0
`define TPG_RESP_SLVERR   2'h2

`endif

// ---- rtl/tpg_pkg.sv ----
// Types shared by the three-port GPIO block
package tpg_pkg;
    typedef logic [7:0] tpg_byte_t;
    typedef enum logic [1:0] {
        TPG_PORT_A = 2'h0,
        TPG_PORT_B = 2'h1,
        TPG_PORT_C = 2'h3
    } tpg_port_t;
endpackage : tpg_pkg

// ---- rtl/tpg_pin_if.sv ----
// Per-port carrier between the register file and a pin driver
interface tpg_pin_if;
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] bbm;
    logic [7:0] oe;
    logic [7:0] out;
    modport regs (output dir, output data, output bbm, input oe, input out);
    modport drv  (input dir, input data, input bbm, output oe, output out);
endinterface : tpg_pin_if

// ---- rtl/tpg_pin_drv.sv ----
// Pin driver of one port with break-before-make delay on turn to output
`include "tpg_regs.svh"

module tpg_pin_drv
    import tpg_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    tpg_pin_if.drv    pins
);
    logic [7:0] dir_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_prev_q <= `TPG_RST_REG;
        end else begin
            dir_prev_q <= pins.dir;
        end
    end

    // Pin newly turned to output stays tri-state one cycle when bbm is set
    always_comb begin
        pins.oe  = pins.dir & ~(pins.bbm & ~dir_prev_q);
        pins.out = pins.data;
    end
endmodule // tpg_pin_drv

// ---- rtl/tpg_gpio_top.sv ----
// AXI4-Lite register file and pin control of the three-port GPIO block
//
// Behaviour
// - Control register bits 7:3 read zero and hold nothing.
// - Port C break-before-make: new output pin tri-stated one cycle first.
// - Port B break-before-make: new output pin tri-stated one cycle first.
// - Port A break-before-make: new output pin tri-stated one cycle first.
// - Port A pull-up, data, direction: eight read/write bits, reset zero.
// - Port B registers implement bits 3:0; bits 7:4 read zero.
// - Port C registers implement bits 5:0; bits 7:6 read zero.
// - Input registers show current pin levels; no reset value.
//
// Design decision made here: the AXI4-Lite register port.
`include "tpg_regs.svh"

module tpg_gpio_top
    import tpg_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [6:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [6:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  port_a_pin_in,
    output logic      [7:0]  port_a_pin_out,
    output logic      [7:0]  port_a_pin_oe,
    output logic      [7:0]  port_a_pullup,
    input  wire logic [3:0]  port_b_pin_in,
    output logic      [3:0]  port_b_pin_out,
    output logic      [3:0]  port_b_pin_oe,
    output logic      [3:0]  port_b_pullup,
    input  wire logic [5:0]  port_c_pin_in,
    output logic      [5:0]  port_c_pin_out,
    output logic      [5:0]  port_c_pin_oe,
    output logic      [5:0]  port_c_pullup
);
    // Register storage, unimplemented bits never written
    tpg_byte_t ctrl_q;
    tpg_byte_t dir_q  [3];
    tpg_byte_t data_q [3];
    tpg_byte_t pue_q  [3];

    // Write channel state
    logic       aw_held_q;
    logic [4:0] aw_idx_q;
    logic       w_held_q;
    logic [7:0] w_byte_q;
    logic       w_lane_q;

    tpg_pin_if pin_a ();
    tpg_pin_if pin_b ();
    tpg_pin_if pin_c ();

    // Implemented-bit mask of a register index; zero means unmapped
    function automatic tpg_byte_t idx_mask(input logic [4:0] idx);
        tpg_byte_t m;
        m = 8'h00;
        case (idx)
            `TPG_IDX_A_IN, `TPG_IDX_A_DIR, `TPG_IDX_A_OUT, `TPG_IDX_A_PUE: m = `TPG_MASK_A;
            `TPG_IDX_B_IN, `TPG_IDX_B_DIR, `TPG_IDX_B_OUT, `TPG_IDX_B_PUE: m = `TPG_MASK_B;
            `TPG_IDX_C_IN, `TPG_IDX_C_DIR, `TPG_IDX_C_OUT, `TPG_IDX_C_PUE: m = `TPG_MASK_C;
            `TPG_IDX_CTRL: m = `TPG_MASK_CTRL;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // Valid index range check; only indices 0x07..0x13 exist
    function automatic logic idx_mapped(input logic [4:0] idx);
        return (idx >= `TPG_IDX_C_IN) && (idx <= `TPG_IDX_CTRL);
    endfunction

    // Port of an index, used by writes only to pick the register slot
    function automatic tpg_port_t idx_port(input logic [4:0] idx);
        tpg_port_t p;
        p = TPG_PORT_A;
        if (idx <= `TPG_IDX_C_PUE) begin
            p = TPG_PORT_C;
        end else if (idx <= `TPG_IDX_B_PUE) begin
            p = TPG_PORT_B;
        end
        return p;
    endfunction

    function automatic int port_slot(input tpg_port_t p);
        int s;
        s = 0;
        case (p)
            TPG_PORT_A: s = 0;
            TPG_PORT_B: s = 1;
            TPG_PORT_C: s = 2;
            default:    s = 0;
        endcase
        return s;
    endfunction

    // Write address and data taken in either order
    logic wr_fire;
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            aw_idx_q      <= 5'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_held_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[6:2];
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            w_byte_q     <= 8'h00;
            w_lane_q     <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wready && s_axi_wvalid) begin
                w_held_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Response waits for both halves; unmapped index answers with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TPG_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= idx_mapped(aw_idx_q) ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register updates; input registers take no write
    logic      do_wr;
    tpg_byte_t wr_val;
    int        wr_slot;
    assign do_wr   = wr_fire && w_lane_q && idx_mapped(aw_idx_q);
    assign wr_val  = w_byte_q & idx_mask(aw_idx_q);
    assign wr_slot = port_slot(idx_port(aw_idx_q));

    // Control register keeps only the three switching enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `TPG_RST_REG;
        end else if (do_wr && aw_idx_q == `TPG_IDX_CTRL) begin
            ctrl_q <= wr_val;
        end
    end

    // Which per-port register an index selects: 1 direction, 2 data, 3 pull-up
    function automatic logic [1:0] idx_kind(input logic [4:0] idx);
        logic [1:0] k;
        k = 2'h0;
        case (idx)
            `TPG_IDX_A_DIR, `TPG_IDX_B_DIR, `TPG_IDX_C_DIR: k = 2'h1;
            `TPG_IDX_A_OUT, `TPG_IDX_B_OUT, `TPG_IDX_C_OUT: k = 2'h2;
            `TPG_IDX_A_PUE, `TPG_IDX_B_PUE, `TPG_IDX_C_PUE: k = 2'h3;
            default: k = 2'h0;
        endcase
        return k;
    endfunction

    // Direction registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                dir_q[i] <= `TPG_RST_REG;
            end
        end else if (do_wr && idx_kind(aw_idx_q) == 2'h1) begin
            dir_q[wr_slot] <= wr_val;
        end
    end

    // Output data registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                data_q[i] <= `TPG_RST_REG;
            end
        end else if (do_wr && idx_kind(aw_idx_q) == 2'h2) begin
            data_q[wr_slot] <= wr_val;
        end
    end

    // Pull-up enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                pue_q[i] <= `TPG_RST_REG;
            end
        end else if (do_wr && idx_kind(aw_idx_q) == 2'h3) begin
            pue_q[wr_slot] <= wr_val;
        end
    end

    // Pin drivers
    assign pin_a.dir  = dir_q[0];
    assign pin_a.data = data_q[0];
    assign pin_a.bbm  = {8{ctrl_q[`TPG_BIT_BBM_A]}};
    assign pin_b.dir  = dir_q[1];
    assign pin_b.data = data_q[1];
    assign pin_b.bbm  = {8{ctrl_q[`TPG_BIT_BBM_B]}};
    assign pin_c.dir  = dir_q[2];
    assign pin_c.data = data_q[2];
    assign pin_c.bbm  = {8{ctrl_q[`TPG_BIT_BBM_C]}};

    tpg_pin_drv u_drv_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pin_a)
    );

    tpg_pin_drv u_drv_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pin_b)
    );

    tpg_pin_drv u_drv_c (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pin_c)
    );

    // Registered pin outputs, one block per port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_pin_oe  <= 8'h00;
            port_a_pin_out <= 8'h00;
            port_a_pullup  <= 8'h00;
        end else begin
            port_a_pin_oe  <= pin_a.oe;
            port_a_pin_out <= pin_a.out;
            port_a_pullup  <= pue_q[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_b_pin_oe  <= 4'h0;
            port_b_pin_out <= 4'h0;
            port_b_pullup  <= 4'h0;
        end else begin
            port_b_pin_oe  <= pin_b.oe[3:0];
            port_b_pin_out <= pin_b.out[3:0];
            port_b_pullup  <= pue_q[1][3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_c_pin_oe  <= 6'h00;
            port_c_pin_out <= 6'h00;
            port_c_pullup  <= 6'h00;
        end else begin
            port_c_pin_oe  <= pin_c.oe[5:0];
            port_c_pin_out <= pin_c.out[5:0];
            port_c_pullup  <= pue_q[2][5:0];
        end
    end

    // Read channel
    function automatic tpg_byte_t rd_value(input logic [4:0] idx);
        tpg_byte_t v;
        v = 8'h00;
        case (idx)
            `TPG_IDX_A_IN:  v = port_a_pin_in;
            `TPG_IDX_B_IN:  v = {4'h0, port_b_pin_in};
            `TPG_IDX_C_IN:  v = {2'h0, port_c_pin_in};
            `TPG_IDX_A_DIR: v = dir_q[0];
            `TPG_IDX_A_OUT: v = data_q[0];
            `TPG_IDX_A_PUE: v = pue_q[0];
            `TPG_IDX_B_DIR: v = dir_q[1];
            `TPG_IDX_B_OUT: v = data_q[1];
            `TPG_IDX_B_PUE: v = pue_q[1];
            `TPG_IDX_C_DIR: v = dir_q[2];
            `TPG_IDX_C_OUT: v = data_q[2];
            `TPG_IDX_C_PUE: v = pue_q[2];
            `TPG_IDX_CTRL:  v = ctrl_q;
            default:        v = 8'h00;
        endcase
        return v & idx_mask(idx);
    endfunction

    // Address accepted only while no read data waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read payload captured at the address handshake, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TPG_RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rdata <= {24'h00_0000, rd_value(s_axi_araddr[6:2])};
            s_axi_rresp <= idx_mapped(s_axi_araddr[6:2]) ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
        end
    end
endmodule // tpg_gpio_top

// ---- dv/tpg_pin_model.sv ----
// Circuitry at the port pins: loopback of driven pins, pull-ups, floating noise
module tpg_pin_model #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] drv_out,
    input  wire logic [W-1:0] drv_oe,
    input  wire logic [W-1:0] pull,
    output logic      [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] noise_q;
    initial noise_q = '0;
    // Floating pins toggle so a stale level never passes for a real one
    always @(posedge clk)
        noise_q <= ~noise_q;
    assign level = (drv_oe & drv_out) | (~drv_oe & (pull | noise_q));
endmodule // tpg_pin_model

// ---- dv/tpg_gpio_sva.sv ----
// Port-level assertions of the three-port GPIO block
`include "tpg_regs.svh"
module tpg_gpio_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [6:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic [6:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic [7:0]  port_a_pin_in,
    input wire logic [7:0]  port_a_pin_out,
    input wire logic [7:0]  port_a_pin_oe,
    input wire logic [3:0]  port_b_pin_oe,
    input wire logic [5:0]  port_c_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] aw_q;
    logic [4:0] ar_q;
    logic [7:0] wd_q;
    logic [2:0] ctrl_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk)
        if (s_axi_awvalid) aw_q <= s_axi_awaddr[6:2];
    always_ff @(posedge aclk)
        if (s_axi_wvalid) wd_q <= s_axi_wdata[7:0];
    always_ff @(posedge aclk)
        if (s_axi_arvalid) ar_q <= s_axi_araddr[6:2];
    // Shadow of the break-before-make enables
    always_ff @(posedge aclk)
        if (!aresetn) ctrl_q <= 3'h0;
        else if ($rose(s_axi_bvalid) && aw_q == `TPG_IDX_CTRL) ctrl_q <= wd_q[2:0];
    property p_rsvd;
        s_axi_rvalid && ar_q == `TPG_IDX_CTRL |-> s_axi_rdata[31:3] == 29'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("ctrl reserved bits set");
    property p_bbm_c;
        $rose(s_axi_bvalid) && aw_q == `TPG_IDX_C_DIR |=> port_c_pin_oe == (ctrl_q[2] ?
            $past(port_c_pin_oe) & wd_q[5:0] : wd_q[5:0]) ##1 port_c_pin_oe == wd_q[5:0];
    endproperty
    a_bbm_c: assert property (p_bbm_c) else $error("port c oe timing");
    property p_bbm_b;
        $rose(s_axi_bvalid) && aw_q == `TPG_IDX_B_DIR |=> port_b_pin_oe == (ctrl_q[1] ?
            $past(port_b_pin_oe) & wd_q[3:0] : wd_q[3:0]) ##1 port_b_pin_oe == wd_q[3:0];
    endproperty
    a_bbm_b: assert property (p_bbm_b) else $error("port b oe timing");
    property p_bbm_a;
        $rose(s_axi_bvalid) && aw_q == `TPG_IDX_A_DIR |=> port_a_pin_oe == (ctrl_q[0] ?
            $past(port_a_pin_oe) & wd_q : wd_q) ##1 port_a_pin_oe == wd_q;
    endproperty
    a_bbm_a: assert property (p_bbm_a) else $error("port a oe timing");
    property p_wid_b;
        s_axi_rvalid && ar_q inside {[5'h0B:5'h0E]} |-> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_wid_b: assert property (p_wid_b) else $error("port b upper bits set");
    property p_wid_c;
        s_axi_rvalid && ar_q inside {[5'h07:5'h0A]} |-> s_axi_rdata[31:6] == 26'h0;
    endproperty
    a_wid_c: assert property (p_wid_c) else $error("port c upper bits set");
    property p_lvl_a;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[6:2] == `TPG_IDX_A_IN |=>
            s_axi_rvalid && s_axi_rdata[7:0] == $past(port_a_pin_in);
    endproperty
    a_lvl_a: assert property (p_lvl_a) else $error("port a level read");
    property p_out_a;
        $rose(s_axi_bvalid) && aw_q == `TPG_IDX_A_OUT |=> port_a_pin_out == wd_q;
    endproperty
    a_out_a: assert property (p_out_a) else $error("port a pin out");
endmodule // tpg_gpio_sva
bind tpg_gpio_top tpg_gpio_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .port_a_pin_in(port_a_pin_in), .port_a_pin_out(port_a_pin_out),
    .port_a_pin_oe(port_a_pin_oe), .port_b_pin_oe(port_b_pin_oe),
    .port_c_pin_oe(port_c_pin_oe)
);

// ---- dv/tpg_gpio_top_tb.sv ----
// Self-checking bench of the three-port GPIO block over AXI4-Lite and its pins
`include "tpg_regs.svh"
module tpg_gpio_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [6:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  port_a_pin_in, port_a_pin_out, port_a_pin_oe, port_a_pullup;
    logic [3:0]  port_b_pin_in, port_b_pin_out, port_b_pin_oe, port_b_pullup;
    logic [5:0]  port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_c_pullup;
    int          error_cnt = 0;
    int          comparisons = 0;
    logic [4:0]  dir_idx [3] = '{`TPG_IDX_A_DIR, `TPG_IDX_B_DIR, `TPG_IDX_C_DIR};
    logic [7:0]  mask_tab [3] = '{`TPG_MASK_A, `TPG_MASK_B, `TPG_MASK_C};
    tpg_gpio_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .port_a_pin_in(port_a_pin_in), .port_a_pin_out(port_a_pin_out),
        .port_a_pin_oe(port_a_pin_oe), .port_a_pullup(port_a_pullup),
        .port_b_pin_in(port_b_pin_in), .port_b_pin_out(port_b_pin_out),
        .port_b_pin_oe(port_b_pin_oe), .port_b_pullup(port_b_pullup),
        .port_c_pin_in(port_c_pin_in), .port_c_pin_out(port_c_pin_out),
        .port_c_pin_oe(port_c_pin_oe), .port_c_pullup(port_c_pullup)
    );
    tpg_pin_model #(.W(8)) u_pa (.clk(aclk), .drv_out(port_a_pin_out), .drv_oe(port_a_pin_oe),
        .pull(port_a_pullup), .level(port_a_pin_in));
    tpg_pin_model #(.W(4)) u_pb (.clk(aclk), .drv_out(port_b_pin_out), .drv_oe(port_b_pin_oe),
        .pull(port_b_pullup), .level(port_b_pin_in));
    tpg_pin_model #(.W(6)) u_pc (.clk(aclk), .drv_out(port_c_pin_out), .drv_oe(port_c_pin_oe),
        .pull(port_c_pullup), .level(port_c_pin_in));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 40) begin
            error_cnt++;
            $display("[ERR] response expected 1 seen 0");
            close_out();
        end
    endtask
    task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        hang(n);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [4:0] idx, input logic [7:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        hang(n);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    function automatic logic [7:0] oe_of(input int p);
        return p == 0 ? port_a_pin_oe : p == 1 ? {4'h0, port_b_pin_oe} : {2'h0, port_c_pin_oe};
    endfunction
    task automatic t_reset();
        for (int i = 8; i < 20; i++)
            if (i != 11 && i != 15) rd(5'(i), 8'h00, 2'h0);
        chk("pins", 32'h0, {port_a_pin_oe, port_a_pin_out, port_b_pullup, port_c_pin_oe});
    endtask
    task automatic t_width();
        for (int p = 0; p < 3; p++)
            for (int k = 0; k < 3; k++) begin
                wr(dir_idx[p] + 5'(k), 8'hFF, 2'h0);
                rd(dir_idx[p] + 5'(k), mask_tab[p], 2'h0);
            end
        chk("oe", 32'h3FFFF, {port_c_pin_oe, port_b_pin_oe, port_a_pin_oe});
        chk("pullup", 32'h3FFFF, {port_c_pullup, port_b_pullup, port_a_pullup});
        wr(`TPG_IDX_CTRL, 8'hFF, 2'h0);
        rd(`TPG_IDX_CTRL, 8'h07, 2'h0);
        wr(`TPG_IDX_A_IN, 8'h00, 2'h0);
        wr(5'h1F, 8'hFF, `TPG_RESP_SLVERR);
        rd(5'h00, 8'h00, `TPG_RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(`TPG_IDX_A_PUE, 8'h00, `TPG_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`TPG_IDX_A_PUE, 8'hFF, `TPG_RESP_OKAY);
    endtask
    task automatic t_inputs();
        for (int p = 0; p < 3; p++) begin
            wr(dir_idx[p] + 5'h1, 8'hA5, 2'h0);
            rd(dir_idx[p] - 5'h1, 8'hA5 & mask_tab[p], 2'h0);
            wr(dir_idx[p], 8'h00, 2'h0);
            rd(dir_idx[p] - 5'h1, mask_tab[p], 2'h0);
        end
    endtask
    // Output enable turn-on delay with the enable of one port at a time
    task automatic t_bbm();
        for (int m = 0; m < 2; m++)
            for (int p = 0; p < 3; p++) begin
                wr(`TPG_IDX_CTRL, m ? 8'h01 << p : 8'h00, 2'h0);
                wr(dir_idx[p], mask_tab[p], 2'h0);
                #1;
                chk("oe early", m ? 8'h00 : mask_tab[p], oe_of(p));
                @(posedge aclk);
                #1;
                chk("oe late", mask_tab[p], oe_of(p));
                wr(dir_idx[p], 8'h00, 2'h0);
                #1;
                chk("oe off", 8'h00, oe_of(p));
            end
    endtask
    // Reset in mid-run clears written registers and pins again
    task automatic t_rerun();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
    endtask
    initial begin
        aresetn = 1'b0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_width();
        t_inputs();
        t_bbm();
        t_rerun();
        close_out();
    end
endmodule // tpg_gpio_top_tb
